// ===== verilog/aspc_pkg.sv
// Constants, register map and helper functions of the asynchronous serial port.
package aspc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_CTRL_A  = 16'h0F95;
  localparam logic [15:0] IDX_CTRL_B  = 16'h0F96;
  localparam logic [15:0] IDX_DATA    = 16'h0F97;
  localparam logic [15:0] ADDR_CTRL_A = 16'(IDX_CTRL_A * 4);
  localparam logic [15:0] ADDR_CTRL_B = 16'(IDX_CTRL_B * 4);
  localparam logic [15:0] ADDR_DATA   = 16'(IDX_DATA * 4);
  localparam logic [1:0]  SEL_A       = 2'h0;
  localparam logic [1:0]  SEL_B       = 2'h1;
  localparam logic [1:0]  SEL_D       = 2'h2;
  localparam logic [1:0]  SEL_NONE    = 2'h3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int CA_TXE    = 7;
  localparam int CA_RXE    = 6;
  localparam int CA_TX_STOP_LEN   = 5;
  localparam int CA_EVEN   = 4;
  localparam int CA_PE     = 3;
  localparam int CA_BRG_HI = 2;
  localparam int CA_BRG_LO = 0;
  localparam int CB_DNC_HI = 2;
  localparam int CB_DNC_LO = 1;
  localparam int CB_RX_STOP_LEN = 0;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [2:0] CTRL_B_RST = 3'h0;
  localparam logic [1:0] ST_LOW_PAD = 2'h0;
  localparam logic [2:0] RATE_TIMER = 3'h6;
  localparam logic [1:0] DNC_OFF    = 2'h0;

  // ---------------------------------------------------------------
  // Bit timing
  // ---------------------------------------------------------------
  localparam logic [3:0] TICK_LAST  = 4'hF;
  localparam logic [3:0] SMP_A      = 4'h7;
  localparam logic [3:0] SMP_B      = 4'h8;
  localparam logic [3:0] SMP_C      = 4'h9;
  localparam logic [3:0] DATA_BITS  = 4'h8;
  localparam logic [3:0] FRAME_BASE = 4'h9;

  function automatic logic [8:0] rate_div(input logic [2:0] code);
    case (code)
      3'h0:    rate_div = 9'h00D;
      3'h1:    rate_div = 9'h01A;
      3'h2:    rate_div = 9'h034;
      3'h3:    rate_div = 9'h068;
      3'h4:    rate_div = 9'h0D0;
      3'h5:    rate_div = 9'h1A0;
      default: rate_div = 9'h060;
    endcase
  endfunction

  function automatic logic [6:0] filt_thr(input logic [1:0] code);
    case (code)
      2'h1:    filt_thr = 7'h1F;
      2'h2:    filt_thr = 7'h3F;
      2'h3:    filt_thr = 7'h7F;
      default: filt_thr = 7'h00;
    endcase
  endfunction

endpackage

// ===== verilog/aspc_glitch_filter.sv
// Receive pin synchroniser and glitch filter.
`timescale 1ns/1ps
module aspc_glitch_filter (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       rx_pin,
  input  wire logic [1:0] mode,
  output wire logic       rx_clean
);
  import aspc_pkg::*;

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       out;
    logic [6:0] cnt;
  } aspc_filt_st_t;

  aspc_filt_st_t r;
  aspc_filt_st_t n;

  // ---------------------------------------------------------------
  // Filter
  // ---------------------------------------------------------------
  // Unless the filter is off, a new level is adopted only after it has held for the full window.
  always_comb begin
    n = r;
    n.s1 = rx_pin;
    n.s2 = r.s1;
    if (mode == DNC_OFF) begin
      n.out = r.s2;
      n.cnt = 7'h00;
    end else if (r.s2 == r.out) begin
      n.cnt = 7'h00;
    end else if (r.cnt == filt_thr(mode) - 7'h01) begin
      n.out = r.s2;
      n.cnt = 7'h00;
    end else begin
      n.cnt = r.cnt + 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r.s1  <= 1'h1;
      r.s2  <= 1'h1;
      r.out <= 1'h1;
      r.cnt <= 7'h00;
    end else begin
      r <= n;
    end
  end

  assign rx_clean = r.out;

  chk_filter_window: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode != DNC_OFF && mode == $past(mode) && $changed(rx_clean))
      |-> $past(r.cnt) == filt_thr(mode) - 7'h01)
    else $error("filtered level changed before the window elapsed");

endmodule

// ===== verilog/aspc_top.sv
// Asynchronous serial port with an AXI4-Lite register slave.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module aspc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output wire logic        wready,
  output wire logic [1:0]  bresp,
  output wire logic        bvalid,
  input  wire logic        bready,
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output wire logic        arready,
  output wire logic [31:0] rdata,
  output wire logic [1:0]  rresp,
  output wire logic        rvalid,
  input  wire logic        rready,
  input  wire logic        aux_timer_match_event,
  input  wire logic        serial_rx_pin,
  output wire logic        serial_tx_pin
);
  import aspc_pkg::*;

  typedef enum logic {TX_IDLE, TX_BIT} aspc_tx_st_t;
  typedef enum logic {RX_IDLE, RX_BIT} aspc_rx_st_t;

  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [2:0]  ctrl_b;
    logic        parity_err_flag;
    logic        frame_err_flag;
    logic        oerr;
    logic        rbfl;
    logic        tx_done_flag;
    logic        tx_empty_flag;
    logic        seen_rx;
    logic        seen_tx;
    logic [7:0]  rxbuf;
    logic [7:0]  txbuf;
    logic        txpend;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_got;
    logic        w_got;
    logic [15:0] awaddr;
    logic [7:0]  wdata;
    logic        wen;
    logic [8:0]  div;
    logic        tick;
    aspc_tx_st_t tx_st;
    logic [11:0] tx_sh;
    logic [3:0]  tx_bits;
    logic [3:0]  tx_tk;
    logic        txd;
    aspc_rx_st_t rx_st;
    logic [3:0]  rx_tk;
    logic [3:0]  rx_idx;
    logic [1:0]  vote;
    logic [7:0]  rx_sh;
    logic        rx_par;
    logic        rx_fe;
  } aspc_core_st_t;

  aspc_core_st_t r;
  aspc_core_st_t n;
  logic          rx_clean;
  logic          wr_tx;
  logic          rd_rx;
  logic          rx_done;
  logic          tx_go;
  logic          bitv;
  logic [1:0]    v;
  logic [2:0]    rate;
  logic          pe;
  logic [3:0]    tk;

  function automatic logic [1:0] reg_sel(input logic [15:0] a);
    if (a[15:2] == ADDR_CTRL_A[15:2])
      reg_sel = SEL_A;
    else if (a[15:2] == ADDR_CTRL_B[15:2])
      reg_sel = SEL_B;
    else if (a[15:2] == ADDR_DATA[15:2])
      reg_sel = SEL_D;
    else
      reg_sel = SEL_NONE;
  endfunction

  aspc_glitch_filter u_filter (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .rx_pin   (serial_rx_pin),
    .mode     (r.ctrl_b[CB_DNC_HI:CB_DNC_LO]),
    .rx_clean (rx_clean)
  );

  always_comb begin
    n = r;
    wr_tx = 1'h0;
    rd_rx = 1'h0;
    rx_done = 1'h0;
    tx_go = 1'h0;
    bitv = 1'h0;
    v = 2'h0;
    tk = 4'h0;
    rate = r.ctrl_a[CA_BRG_HI:CA_BRG_LO];
    pe = r.ctrl_a[CA_PE];

    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    if (r.awready && awvalid) begin
      n.aw_got = 1'h1;
      n.awaddr = awaddr;
      n.awready = 1'h0;
    end
    if (r.wready && wvalid) begin
      n.w_got = 1'h1;
      n.wdata = wdata[7:0];
      n.wen = wstrb[0];
      n.wready = 1'h0;
    end
    if (r.aw_got && r.w_got) begin
      n.aw_got = 1'h0;
      n.w_got = 1'h0;
      n.bvalid = 1'h1;
      n.bresp = RESP_OKAY;
      case (reg_sel(r.awaddr))
        SEL_A: if (r.wen) n.ctrl_a = r.wdata;
        SEL_B: if (r.wen) n.ctrl_b = r.wdata[2:0];
        SEL_D: wr_tx = r.wen;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'h0;
      n.awready = 1'h1;
      n.wready = 1'h1;
    end
    if (r.arready && arvalid) begin
      n.arready = 1'h0;
      n.rvalid = 1'h1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0000_0000;
      case (reg_sel(araddr))
        SEL_A: begin
          n.rdata[7:0] = {r.parity_err_flag, r.frame_err_flag, r.oerr, r.rbfl, r.tx_done_flag, r.tx_empty_flag, ST_LOW_PAD};
          n.seen_rx = 1'h1;
          n.seen_tx = 1'h1;
        end
        SEL_B: n.rresp = RESP_OKAY;
        SEL_D: begin
          n.rdata[7:0] = r.rxbuf;
          rd_rx = 1'h1;
        end
        default: n.rresp = RESP_SLVERR;
      endcase
    end
    if (r.rvalid && rready) begin
      n.rvalid = 1'h0;
      n.arready = 1'h1;
    end
    // Clears go first so that a flag set by the receiver below wins.
    if (rd_rx && r.seen_rx) begin
      n.parity_err_flag = 1'h0;
      n.frame_err_flag = 1'h0;
      n.oerr = 1'h0;
      n.rbfl = 1'h0;
      n.seen_rx = 1'h0;
    end

    // ---------------------------------------------------------------
    // Sample tick generator
    // ---------------------------------------------------------------
    if (rate == RATE_TIMER) begin
      n.div = 9'h000;
      n.tick = aux_timer_match_event;
    end else if (r.div >= rate_div(rate) - 9'h001) begin
      n.div = 9'h000;
      n.tick = 1'h1;
    end else begin
      n.div = r.div + 9'h001;
      n.tick = 1'h0;
    end

    // ---------------------------------------------------------------
    // Transmitter
    // ---------------------------------------------------------------
    // Enables are only looked at in idle, so a frame in flight always ends.
    if (r.tick) begin
      case (r.tx_st)
        TX_IDLE: begin
          if (r.ctrl_a[CA_TXE] && r.txpend) begin
            tx_go = 1'h1;
            n.tx_st = TX_BIT;
            if (pe)
              n.tx_sh = {2'h3, (^r.txbuf) ^ ~r.ctrl_a[CA_EVEN], r.txbuf, 1'h0};
            else
              n.tx_sh = {3'h7, r.txbuf, 1'h0};
            n.tx_bits = FRAME_BASE + {3'h0, pe} + {3'h0, r.ctrl_a[CA_TX_STOP_LEN]};
            n.tx_tk = 4'h0;
            n.txd = 1'h0;
            n.txpend = 1'h0;
            n.tx_empty_flag = 1'h1;
            n.tx_done_flag = 1'h0;
          end
        end
        TX_BIT: begin
          if (r.tx_tk == TICK_LAST) begin
            n.tx_tk = 4'h0;
            if (r.tx_bits == 4'h0) begin
              n.tx_st = TX_IDLE;
              n.txd = 1'h1;
              if (!r.txpend)
                n.tx_done_flag = 1'h1;
            end else begin
              n.tx_sh = {1'h1, r.tx_sh[11:1]};
              n.txd = r.tx_sh[1];
              n.tx_bits = r.tx_bits - 4'h1;
            end
          end else begin
            n.tx_tk = r.tx_tk + 4'h1;
          end
        end
        default: n.tx_st = TX_IDLE;
      endcase
    end
    // A write without a prior status read is dropped and starts nothing.
    if (wr_tx && r.seen_tx) begin
      n.txbuf = r.wdata;
      n.txpend = 1'h1;
      n.tx_empty_flag = 1'h0;
      n.seen_tx = 1'h0;
    end

    // ---------------------------------------------------------------
    // Receiver
    // ---------------------------------------------------------------
    // Receiving stays blocked while an overrun is still flagged.
    if (r.tick) begin
      case (r.rx_st)
        RX_IDLE: begin
          if (r.ctrl_a[CA_RXE] && !r.oerr && !rx_clean) begin
            n.rx_st = RX_BIT;
            n.rx_tk = 4'h0;
            n.rx_idx = 4'h0;
            n.vote = 2'h0;
            n.rx_fe = 1'h0;
          end
        end
        RX_BIT: begin
          tk = r.rx_tk + 4'h1;
          n.rx_tk = tk;
          if (tk == SMP_A || tk == SMP_B)
            n.vote = r.vote + {1'h0, rx_clean};
          if (tk == SMP_C) begin
            v = r.vote + {1'h0, rx_clean};
            bitv = v[1];
            n.vote = 2'h0;
            n.rx_idx = r.rx_idx + 4'h1;
            if (r.rx_idx == 4'h0) begin
              if (bitv)
                n.rx_st = RX_IDLE;
            end else if (r.rx_idx <= DATA_BITS) begin
              n.rx_sh = {bitv, r.rx_sh[7:1]};
            end else if (pe && r.rx_idx == FRAME_BASE) begin
              n.rx_par = bitv;
            end else if (!bitv) begin
              n.rx_fe = 1'h1;
            end
            if (r.rx_idx == FRAME_BASE + {3'h0, pe} + {3'h0, r.ctrl_b[CB_RX_STOP_LEN]}) begin
              rx_done = 1'h1;
              n.rx_st = RX_IDLE;
            end
          end
        end
        default: n.rx_st = RX_IDLE;
      endcase
    end
    if (rx_done) begin
      if (n.rbfl) begin
        n.oerr = 1'h1;
      end else begin
        n.rxbuf = n.rx_sh;
        n.rbfl = 1'h1;
        if (n.rx_fe)
          n.frame_err_flag = 1'h1;
        if (pe && (((^n.rx_sh) ^ ~r.ctrl_a[CA_EVEN]) != n.rx_par))
          n.parity_err_flag = 1'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.ctrl_a <= CTRL_A_RST;
      r.ctrl_b <= CTRL_B_RST;
      r.tx_done_flag <= 1'h1;
      r.tx_empty_flag <= 1'h1;
      r.awready <= 1'h1;
      r.wready <= 1'h1;
      r.arready <= 1'h1;
      r.txd <= 1'h1;
    end else begin
      r <= n;
    end
  end

  assign awready = r.awready;
  assign wready = r.wready;
  assign bresp = r.bresp;
  assign bvalid = r.bvalid;
  assign arready = r.arready;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign rvalid = r.rvalid;
  assign serial_tx_pin = r.txd;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_tx_idle_high: assert property ((r.tx_st == TX_IDLE) |-> serial_tx_pin)
    else $error("transmit pin low while idle");
  chk_start_low: assert property (tx_go |=> !serial_tx_pin && r.tx_st == TX_BIT && r.tx_tk == 4'h0)
    else $error("start bit not driven low");
  chk_tx_empty_flag_start: assert property (tx_go |=> r.tx_empty_flag && !r.tx_done_flag && !r.txpend)
    else $error("empty flag not set at transmit start");
  chk_reset_flags: assert property ($past(!aresetn) |->
    !r.parity_err_flag && !r.frame_err_flag && !r.oerr && !r.rbfl && r.tx_done_flag && r.tx_empty_flag && r.ctrl_a == CTRL_A_RST)
    else $error("status not at reset value");
  chk_overrun_keep: assert property ($rose(r.oerr) |-> $stable(r.rxbuf) && r.rbfl)
    else $error("overrun changed the receive buffer");
  chk_rate_fast: assert property ((r.tick && rate == 3'h0) |=> (!r.tick || rate != 3'h0) [*8])
    else $error("sample tick too fast for the fastest rate");
  chk_rx_clear: assert property ((rd_rx && r.seen_rx && !rx_done) |=> !r.parity_err_flag && !r.frame_err_flag && !r.rbfl)
    else $error("receive flags not cleared by buffer read");
  chk_write_gate: assert property ((wr_tx && !r.seen_tx && !r.txpend) |=> !r.txpend ##1 !tx_go)
    else $error("transmit write accepted without status read");

endmodule

// ===== tb/aspc_remote_uart.sv
// Behavioural model of the remote serial transmitter and receiver.
`timescale 1ns/1ps
module aspc_remote_uart (
  input  wire logic serial_tx_pin,
  output logic      serial_rx_pin
);

  // ---------------------------------------------------------------
  // Transmit side, drives the device receive pin
  // ---------------------------------------------------------------
  // The line idles high between frames, as a real remote transmitter does.
  initial serial_rx_pin = 1'b1;

  task automatic send(input logic [7:0] d, input bit pen, input bit even, input bit bad_par,
                      input int nstop, input bit bad_stop, input bit glitch, input int bit_ns);
    int i;
    serial_rx_pin = 1'b0;
    #(bit_ns);
    for (i = 0; i < 8; i++) begin
      serial_rx_pin = d[i];
      if (glitch && i == 0) begin
        // A short flip mid-bit can upset at most one of the three votes.
        #(bit_ns / 2 - 20);
        serial_rx_pin = ~d[0];
        #40;
        serial_rx_pin = d[0];
        #(bit_ns / 2 - 20);
      end else begin
        #(bit_ns);
      end
    end
    if (pen) begin
      serial_rx_pin = (^d) ^ ~even ^ bad_par;
      #(bit_ns);
    end
    for (i = 0; i < nstop; i++) begin
      serial_rx_pin = !(bad_stop && i == nstop - 1);
      #(bit_ns);
    end
    serial_rx_pin = 1'b1;
  endtask

  task automatic pulse(input int ns);
    serial_rx_pin = 1'b0;
    #(ns);
    serial_rx_pin = 1'b1;
  endtask

  // ---------------------------------------------------------------
  // Receive side, samples the device transmit pin mid-bit
  // ---------------------------------------------------------------
  task automatic recv(input bit pen, input int nstop, input int bit_ns,
                      output logic [7:0] d, output logic p, output logic [1:0] st);
    int i;
    st = 2'b11;
    p = 1'b0;
    @(negedge serial_tx_pin);
    #(bit_ns / 2);
    for (i = 0; i < 8; i++) begin
      #(bit_ns);
      d[i] = serial_tx_pin;
    end
    if (pen) begin
      #(bit_ns);
      p = serial_tx_pin;
    end
    for (i = 0; i < nstop; i++) begin
      #(bit_ns);
      st[i] = serial_tx_pin;
    end
  endtask

endmodule

// ===== tb/test_async_serial_port_config.sv
// Self-checking testbench of the asynchronous serial port.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module test_async_serial_port_config;
  import aspc_pkg::*;

  // ---------------------------------------------------------------
  // Signals and tables
  // ---------------------------------------------------------------
  localparam int BIT_NS = 1040;
  localparam int LIMIT  = 90000;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, aux_timer_match_event;
  logic awready, wready, bvalid, arready, rvalid, serial_rx_pin, serial_tx_pin;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, tdiv, r;
  logic [31:0] v;
  logic [7:0]  d, ca;
  logic        p;
  logic [1:0]  st;
  logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h6};
  int          bit_tab [5] = '{1040, 2080, 4160, 7680, 320};
  logic [7:0]  tx_bytes [5] = '{8'hA5, 8'h0F, 8'h3C, 8'hC3, 8'h5A};
  int          failures, checked, cycles, i, n, bad;

  aspc_top aspc_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .aux_timer_match_event(aux_timer_match_event), .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin(serial_tx_pin));
  aspc_remote_uart aspc_remote_uart_inst (.serial_tx_pin(serial_tx_pin), .serial_rx_pin(serial_rx_pin));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // The timer event fires every fourth cycle, so one bit lasts 64 cycles.
  always @(posedge aclk) begin
    tdiv <= tdiv + 2'h1;
    aux_timer_match_event <= (tdiv == 2'h3);
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Bus tasks; bready and rready stay high, which the bus allows
  // ---------------------------------------------------------------
  task automatic axi_write(input logic [15:0] a, input logic [31:0] dat, output logic [1:0] resp);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
  endtask

  task automatic axi_read(input logic [15:0] a, output logic [31:0] dat, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    dat = rdata;
    resp = rresp;
  endtask

  task automatic chk_reg(input logic [15:0] a, input logic [7:0] e);
    logic [31:0] val;
    logic [1:0]  rs;
    axi_read(a, val, rs);
    `CHK(val, {24'h000000, e})
    `CHK(rs, RESP_OKAY)
  endtask

  task automatic frame_in(input logic [7:0] dat, input bit bad_par, input int nstop,
                          input bit bad_stop, input bit gl);
    aspc_remote_uart_inst.send(dat, 1'b1, 1'b1, bad_par, nstop, bad_stop, gl, BIT_NS);
    @(posedge aclk);
    repeat (40) @(posedge aclk);
  endtask

  task automatic finish_test();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h00000000;
    wstrb = 4'h1;
    tdiv = 2'h0;
    aux_timer_match_event = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_reg(ADDR_CTRL_B, 8'h00);
    axi_read(16'h0000, v, r);
    `CHK(r, RESP_SLVERR)
    axi_write(16'h0000, 32'h000000FF, r);
    `CHK(r, RESP_SLVERR)
    // Enabled, data written before any status read since reset: the pin must stay idle.
    axi_write(ADDR_CTRL_A, 32'h00000080, r);
    axi_write(ADDR_DATA, 32'h00000055, r);
    bad = 0;
    repeat (400) begin
      @(posedge aclk);
      if (serial_tx_pin !== 1'b1) bad++;
    end
    `CHK(bad, 0)
    chk_reg(ADDR_CTRL_A, 8'h0C);
    chk_reg(ADDR_CTRL_A, 8'h0C);
    for (i = 0; i < 5; i++) begin
      ca = {2'h0, i[0], ~i[0], 1'b1, codes[i]};
      axi_write(ADDR_CTRL_A, 32'h00000000, r);
      axi_write(ADDR_CTRL_A, {24'h000000, ca}, r);
      axi_write(ADDR_CTRL_A, {24'h000000, ca | 8'h80}, r);
      axi_read(ADDR_CTRL_A, v, r);
      fork
        aspc_remote_uart_inst.recv(1'b1, i % 2 + 1, bit_tab[i], d, p, st);
        begin
          axi_write(ADDR_DATA, {24'h000000, tx_bytes[i]}, r);
          @(negedge serial_tx_pin);
          chk_reg(ADDR_CTRL_A, 8'h04);
          if (i == 1) axi_write(ADDR_CTRL_A, {24'h000000, ca}, r);
        end
      join
      @(posedge aclk);
      `CHK(d, tx_bytes[i])
      `CHK(p, ^tx_bytes[i] ^ i[0])
      `CHK(st, 2'b11)
      chk_reg(ADDR_CTRL_A, 8'h04);
      n = 0;
      do begin
        axi_read(ADDR_CTRL_A, v, r);
        n++;
      end while (v[7:0] !== 8'h0C && n < 3000);
      `CHK(v[7:0], 8'h0C)
    end
    // Receive at the fastest divider with even parity.
    axi_write(ADDR_CTRL_A, 32'h00000000, r);
    axi_write(ADDR_CTRL_A, 32'h00000018, r);
    axi_write(ADDR_CTRL_A, 32'h00000058, r);
    frame_in(8'h96, 1'b0, 1, 1'b0, 1'b1);
    chk_reg(ADDR_CTRL_A, 8'h1C);
    chk_reg(ADDR_DATA, 8'h96);
    chk_reg(ADDR_CTRL_A, 8'h0C);
    frame_in(8'h5A, 1'b1, 1, 1'b0, 1'b0);
    chk_reg(ADDR_CTRL_A, 8'h9C);
    axi_read(ADDR_DATA, v, r);
    chk_reg(ADDR_CTRL_A, 8'h0C);
    axi_write(ADDR_CTRL_B, 32'h00000001, r);
    frame_in(8'h33, 1'b0, 2, 1'b1, 1'b0);
    chk_reg(ADDR_CTRL_A, 8'h5C);
    axi_read(ADDR_DATA, v, r);
    chk_reg(ADDR_CTRL_A, 8'h0C);
    axi_write(ADDR_CTRL_B, 32'h00000000, r);
    frame_in(8'h11, 1'b0, 1, 1'b0, 1'b0);
    frame_in(8'h22, 1'b0, 1, 1'b0, 1'b0);
    chk_reg(ADDR_CTRL_A, 8'h3C);
    chk_reg(ADDR_DATA, 8'h11);
    chk_reg(ADDR_CTRL_A, 8'h0C);
    // Shortest filter setting: a 20-cycle dip is noise, a 208-cycle bit is signal.
    axi_write(ADDR_CTRL_B, 32'h00000002, r);
    aspc_remote_uart_inst.pulse(100);
    @(posedge aclk);
    repeat (400) @(posedge aclk);
    chk_reg(ADDR_CTRL_A, 8'h0C);
    frame_in(8'h77, 1'b0, 1, 1'b0, 1'b0);
    chk_reg(ADDR_CTRL_A, 8'h1C);
    chk_reg(ADDR_DATA, 8'h77);
    finish_test();
  end

endmodule
